// file: design/spc_regs.sv
// system protect key, internal ram size and flash read cycle registers on avalon-mm
`timescale 1ns/1ps
// Contract
// - protection is off only while the key register holds exactly 0x0096
// - while protected, writes to ram size and flash wait fields are dropped
// - key register is 16 bits read/write, resets to 0x0000 so protected
// - unlock persists until software writes a value other than the key
// - ram size code 0 is 512B, 1 is 1KB, 2 is 2KB; 3-7 reserved
// - flash read takes wait field plus one bus cycles, one to four
module spc_regs (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic i_CE,
  input wire logic [spc_pkg::SPC_ADDR_W-1:0] i_AVS_ADDRESS,
  input wire logic i_AVS_READ,
  input wire logic i_AVS_WRITE,
  input wire logic [31:0] i_AVS_WRITEDATA,
  input wire logic [3:0] i_AVS_BYTEENABLE,
  output logic [31:0] o_AVS_READDATA,
  output logic o_AVS_WAITREQUEST,
  output logic o_UNLOCKED,
  output logic [2:0] o_RAM_SIZE_SELECT,
  output logic [10:0] o_RAM_BYTES_M1,
  output logic [1:0] o_FLASH_WAIT_SELECT,
  output logic [2:0] o_FLASH_CYCLES_M1
);
  import spc_pkg::*;

  spc_state_t s_q;
  spc_state_t s_d;
  spc_avm_req_t req;
  logic [15:0] key_nx;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  // usable ram size in bytes minus one
  function automatic logic [10:0] ram_bytes(input logic [2:0] sel);
    unique case (sel)
      SPC_RAM_512B: ram_bytes = 11'h1FF;
      SPC_RAM_1KB: ram_bytes = 11'h3FF;
      SPC_RAM_2KB: ram_bytes = 11'h7FF;
      default: ram_bytes = 11'h7FF;
    endcase
  endfunction

  assign req = '{address: i_AVS_ADDRESS, read: i_AVS_READ, write: i_AVS_WRITE,
                 writedata: i_AVS_WRITEDATA, byteenable: i_AVS_BYTEENABLE};

  // bus slave and register next state
  always_comb begin
    s_d = s_q;
    key_nx = merge16(s_q.key, req.writedata, req.byteenable);
    s_d.waitreq = 1'b1;
    if (s_q.phase == SPC_DONE) begin
      s_d.phase = SPC_IDLE;
    end else if (req.read || req.write) begin
      s_d.phase = SPC_DONE;
      s_d.waitreq = 1'b0;
      s_d.rdata = SPC_UNMAPPED_RD;
      if (req.write) begin
        unique case (req.address)
          SPC_ADDR_KEY: begin
            s_d.key = key_nx;
          end
          SPC_ADDR_RAM: begin
            if (s_q.unlocked) begin
              if (req.byteenable[0]) begin
                s_d.ram_sel = req.writedata[2:0];
              end
              if (req.byteenable[1]) begin
                s_d.ram_rsv = req.writedata[SPC_RSV_BIT];
              end
            end
          end
          SPC_ADDR_FLASH: begin
            if (s_q.unlocked) begin
              if (req.byteenable[0]) begin
                s_d.wait_sel = req.writedata[1:0];
              end
              if (req.byteenable[1]) begin
                s_d.wait_rsv = req.writedata[SPC_RSV_BIT];
              end
            end
          end
          default: begin
          end
        endcase
      end else begin
        unique case (req.address)
          SPC_ADDR_KEY: s_d.rdata = {16'h0000, s_q.key};
          SPC_ADDR_RAM: s_d.rdata = {23'h000000, s_q.ram_rsv, SPC_RAM_FIXED, s_q.ram_sel};
          SPC_ADDR_FLASH: s_d.rdata = {23'h000000, s_q.wait_rsv, 6'h00, s_q.wait_sel};
          default: s_d.rdata = SPC_UNMAPPED_RD;
        endcase
      end
    end
    s_d.unlocked = (s_d.key == SPC_KEY_UNLOCK);
    s_d.flash_cycles = {1'b0, s_d.wait_sel};
    s_d.ram_bytes_m1 = ram_bytes(s_d.ram_sel);
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s_q <= '{phase: SPC_IDLE, waitreq: 1'b1, rdata: 32'h0000_0000, key: SPC_KEY_RST,
               ram_sel: SPC_RAM_RST, ram_rsv: SPC_RAM_RSV_RST, wait_sel: SPC_WAIT_RST,
               wait_rsv: SPC_WAIT_RSV_RST, unlocked: 1'b0, flash_cycles: 3'h1,
               ram_bytes_m1: 11'h7FF};
    end else if (i_CE) begin
      s_q <= s_d;
    end
  end

  assign o_AVS_READDATA = s_q.rdata;
  assign o_AVS_WAITREQUEST = s_q.waitreq;
  assign o_UNLOCKED = s_q.unlocked;
  assign o_RAM_SIZE_SELECT = s_q.ram_sel;
  assign o_RAM_BYTES_M1 = s_q.ram_bytes_m1;
  assign o_FLASH_WAIT_SELECT = s_q.wait_sel;
  assign o_FLASH_CYCLES_M1 = s_q.flash_cycles;
endmodule

// file: design/spc_pkg.sv
// package for the system protect configuration register bank
package spc_pkg;
  // avalon word addresses (byte address = 4 * index)
  localparam logic [3:0] SPC_ADDR_KEY = 4'h0;
  localparam logic [3:0] SPC_ADDR_RAM = 4'h1;
  localparam logic [3:0] SPC_ADDR_FLASH = 4'h2;
  localparam int SPC_ADDR_W = 4;
  // unlock key and reset values
  localparam logic [15:0] SPC_KEY_UNLOCK = 16'h0096;
  localparam logic [15:0] SPC_KEY_RST = 16'h0000;
  localparam logic [2:0] SPC_RAM_RST = 3'h2;
  localparam logic SPC_RAM_RSV_RST = 1'b0;
  localparam logic [4:0] SPC_RAM_FIXED = 5'h04;
  localparam logic [1:0] SPC_WAIT_RST = 2'h1;
  localparam logic SPC_WAIT_RSV_RST = 1'b1;
  // field positions
  localparam int SPC_RSV_BIT = 8;
  localparam int SPC_RAM_FIX_LSB = 3;
  // ram size codes
  localparam logic [2:0] SPC_RAM_512B = 3'h0;
  localparam logic [2:0] SPC_RAM_1KB = 3'h1;
  localparam logic [2:0] SPC_RAM_2KB = 3'h2;
  // bus answer for unmapped addresses
  localparam logic [31:0] SPC_UNMAPPED_RD = 32'h0000_0000;

  typedef enum logic [0:0] {
    SPC_IDLE = 1'b0,
    SPC_DONE = 1'b1
  } spc_phase_t;

  typedef struct packed {
    logic [SPC_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } spc_avm_req_t;

  typedef struct packed {
    spc_phase_t phase;
    logic waitreq;
    logic [31:0] rdata;
    logic [15:0] key;
    logic [2:0] ram_sel;
    logic ram_rsv;
    logic [1:0] wait_sel;
    logic wait_rsv;
    logic unlocked;
    logic [2:0] flash_cycles;
    logic [10:0] ram_bytes_m1;
  } spc_state_t;
endpackage

// file: dv/spc_regs_properties.sv
// assertions for the protect config bank
`timescale 1ns/1ps
module spc_props import spc_pkg::*; (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic [SPC_ADDR_W-1:0] i_AVS_ADDRESS,
  input wire logic i_AVS_READ,
  input wire logic [31:0] o_AVS_READDATA,
  input wire logic o_AVS_WAITREQUEST,
  input wire logic o_UNLOCKED,
  input wire logic [2:0] o_RAM_SIZE_SELECT,
  input wire logic [10:0] o_RAM_BYTES_M1,
  input wire logic [1:0] o_FLASH_WAIT_SELECT,
  input wire logic [2:0] o_FLASH_CYCLES_M1
);
  // lock state only moves on a bus acknowledge
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_RSTN);
  chk_unlock_at_ack: assert property ($rose(o_UNLOCKED) |-> $fell(o_AVS_WAITREQUEST))
    else $error("unlock without ack");
  chk_relock_at_ack: assert property ($fell(o_UNLOCKED) |-> $fell(o_AVS_WAITREQUEST))
    else $error("relock without ack");
  // protected fields frozen while locked
  chk_ram_locked: assert property (!o_UNLOCKED |=> $stable(o_RAM_SIZE_SELECT))
    else $error("ram field moved while locked");
  chk_wait_locked: assert property (!o_UNLOCKED |=> $stable(o_FLASH_WAIT_SELECT))
    else $error("wait field moved while locked");
  // decoded outputs follow their fields
  chk_ram_bytes: assert property (o_RAM_BYTES_M1 == (o_RAM_SIZE_SELECT == SPC_RAM_512B ? 11'h1FF :
    o_RAM_SIZE_SELECT == SPC_RAM_1KB ? 11'h3FF : 11'h7FF)) else $error("ram bytes wrong");
  chk_flash_cycles: assert property (o_FLASH_CYCLES_M1 == {1'b0, o_FLASH_WAIT_SELECT})
    else $error("flash cycles wrong");
  // reserved read-only bits read fixed values
  chk_ram_read: assert property (!o_AVS_WAITREQUEST && i_AVS_READ && i_AVS_ADDRESS == SPC_ADDR_RAM |->
    {o_AVS_READDATA[31:9], o_AVS_READDATA[7:0]} == {23'h0, SPC_RAM_FIXED, o_RAM_SIZE_SELECT})
    else $error("ram read wrong");
  chk_flash_read: assert property (!o_AVS_WAITREQUEST && i_AVS_READ && i_AVS_ADDRESS == SPC_ADDR_FLASH |->
    {o_AVS_READDATA[31:9], o_AVS_READDATA[7:0]} == {29'h0, o_FLASH_WAIT_SELECT})
    else $error("flash read wrong");
endmodule
bind spc_regs spc_props spc_props_inst (.I_CLK, .I_RSTN, .i_AVS_ADDRESS, .i_AVS_READ, .o_AVS_READDATA,
  .o_AVS_WAITREQUEST, .o_UNLOCKED, .o_RAM_SIZE_SELECT, .o_RAM_BYTES_M1, .o_FLASH_WAIT_SELECT, .o_FLASH_CYCLES_M1);

// file: dv/spc_regs_tb.sv
// bench for the protect config bank
`timescale 1ns/1ps
module spc_regs_tb;
  import spc_pkg::*;
  logic I_CLK = 0, I_RSTN = 0, rd_q = 0, wr_q = 0, wrq;
  logic [3:0] adr_q = 0;
  logic [31:0] wd_q = 0, rdat;
  logic ce_q = 1, unl;
  logic [10:0] rbm;
  logic [2:0] fcm;
  int err_count = 0, cmp_count = 0, cyc = 0;
  initial forever #2 I_CLK = ~I_CLK;
  spc_regs spc_regs_inst (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .i_CE(ce_q), .i_AVS_ADDRESS(adr_q), .i_AVS_READ(rd_q),
    .i_AVS_WRITE(wr_q), .i_AVS_WRITEDATA(wd_q), .i_AVS_BYTEENABLE(4'hF), .o_AVS_READDATA(rdat),
    .o_AVS_WAITREQUEST(wrq), .o_UNLOCKED(unl), .o_RAM_SIZE_SELECT(), .o_RAM_BYTES_M1(rbm),
    .o_FLASH_WAIT_SELECT(), .o_FLASH_CYCLES_M1(fcm));
  // status outputs against expected levels
  task automatic chk_out(input logic u, input logic [10:0] b, input logic [2:0] f);
    cmp_count++;
    if (unl !== u || rbm !== b || fcm !== f) begin
      err_count++;
      $display("mismatch %0t status %b %h %h", $time, unl, rbm, fcm);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    wr_q <= w;
    rd_q <= !w;
    adr_q <= a;
    wd_q <= d;
    do @(posedge I_CLK); while (wrq !== 1'b0);
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask
  task automatic chk(input logic [3:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp_count++;
    if (rdat !== e) begin
      err_count++;
      $display("mismatch %0t addr %h got %h", $time, a, rdat);
    end
  endtask
  // reset pulse then reset values
  task automatic rst_chk;
    I_RSTN <= 1'b0;
    repeat (6) @(posedge I_CLK);
    I_RSTN <= 1'b1;
    chk(SPC_ADDR_KEY, 32'h0);
    chk(SPC_ADDR_RAM, 32'h22);
    chk(SPC_ADDR_FLASH, 32'h101);
    chk_out(1'b0, 11'h7FF, 3'h1);
  endtask
  task automatic summarize;
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    rst_chk();
    xfer(1'b1, SPC_ADDR_RAM, 32'h0);
    xfer(1'b1, SPC_ADDR_FLASH, 32'h103);
    xfer(1'b1, SPC_ADDR_KEY, 32'h196);
    xfer(1'b1, SPC_ADDR_RAM, 32'h0);
    chk(SPC_ADDR_KEY, 32'h196);
    chk(SPC_ADDR_RAM, 32'h22);
    chk(SPC_ADDR_FLASH, 32'h101);
    chk_out(1'b0, 11'h7FF, 3'h1);
    xfer(1'b1, SPC_ADDR_KEY, 32'h96);
    chk_out(1'b1, 11'h7FF, 3'h1);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, SPC_ADDR_FLASH, 32'h100 | i);
      chk(SPC_ADDR_FLASH, 32'h100 | i);
      xfer(1'b1, SPC_ADDR_RAM, 32'h0 + i % 3);
      chk(SPC_ADDR_RAM, 32'h20 + i % 3);
      chk_out(1'b1, (i % 3 == 0) ? 11'h1FF : (i % 3 == 1) ? 11'h3FF : 11'h7FF, 3'(i));
    end
    xfer(1'b1, 4'h3, 32'hFFFF);
    chk(4'h3, 32'h0);
    chk(SPC_ADDR_KEY, 32'h96);
    // relock write held while clock enable is low: nothing may move
    @(posedge I_CLK);
    ce_q <= 1'b0;
    wr_q <= 1'b1;
    adr_q <= SPC_ADDR_KEY;
    wd_q <= 32'h0;
    repeat (3) @(posedge I_CLK);
    cmp_count++;
    if (wrq !== 1'b1 || unl !== 1'b1) begin
      err_count++;
      $display("mismatch %0t clock enable freeze", $time);
    end
    ce_q <= 1'b1;
    do @(posedge I_CLK); while (wrq !== 1'b0);
    wr_q <= 1'b0;
    chk_out(1'b0, 11'h1FF, 3'h3);
    xfer(1'b1, SPC_ADDR_FLASH, 32'h100);
    chk(SPC_ADDR_FLASH, 32'h103);
    rst_chk();
    summarize();
  end
endmodule
